// >>> logic/sfep_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
module sfep_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic empty_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sfep_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign empty_o = (count == '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_wr_ptr = wr_ptr + (push ? AW'(1) : AW'(0));
    next_rd_ptr = rd_ptr + (pop ? AW'(1) : AW'(0));
    next_count = count + (push ? (AW+1)'(1) : '0) - (pop ? (AW+1)'(1) : '0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage carries no reset; only the pointers and count define what is valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // sfep_fifo

// >>> logic/sfep_sequencer.sv
// Erase, page program and deep power-down command handling of a serial flash.
// Assumes select, clock and data lines come from the host's domain and are
// sampled here; an array controller drains staged page bytes and runs the ops.
`include "sfep_consts.svh"

module sfep_sequencer #(
  parameter int unsigned BLOCK64_ERASE_CYC = `SFEP_US2CYC(`SFEP_BLOCK64_ERASE_TIME_US),
  parameter int unsigned BLOCK32_ERASE_CYC = `SFEP_US2CYC(`SFEP_BLOCK32_ERASE_TIME_US),
  parameter int unsigned ARRAY_ERASE_CYC = `SFEP_US2CYC(`SFEP_ARRAY_ERASE_TIME_US),
  parameter int unsigned PAGE_WRITE_CYC = `SFEP_US2CYC(`SFEP_PAGE_WRITE_TIME_US),
  parameter int unsigned FIFO_DEPTH = `SFEP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] quad_data_lines_i,
  input wire logic quad_lines_enable_bit_i,
  input wire logic [3:0] block_protect_bits_i,
  output logic cycle_in_progress_bit_o,
  output logic write_unlock_latch_o,
  output logic sleeping_o,
  output logic op_valid_o,
  output sfep_pkg::sfep_op_t op_kind_o,
  output logic [23:0] op_addr_o,
  output logic page_byte_valid_o,
  input wire logic page_byte_ready_i,
  output logic [7:0] page_byte_col_o,
  output logic [7:0] page_byte_o
);
  localparam int unsigned SLEEP_ENTRY_CYC = `SFEP_US2CYC(`SFEP_SLEEP_ENTRY_DELAY_US);
  localparam int unsigned SLEEP_EXIT_CYC = `SFEP_US2CYC(`SFEP_SLEEP_EXIT_DELAY_US);

  if (BLOCK64_ERASE_CYC < 1 || BLOCK32_ERASE_CYC < 1 || ARRAY_ERASE_CYC < 1 ||
      PAGE_WRITE_CYC < 1 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("sfep_sequencer: cycle counts must be at least 1, FIFO depth at least 2");
  end

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  // Bit 5 select, bit 4 clock, bits 3..0 data lines
  logic [5:0] sync1, sync2;
  logic cs_d, sclk_d;
  logic cs_rise, cs_fall, cs_low, sclk_rise;
  logic [3:0] sio;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 6'h20;
      sync2 <= 6'h20;
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      sync1 <= {cs_n_i, sclk_i, quad_data_lines_i};
      sync2 <= sync1;
      cs_d <= sync2[5];
      sclk_d <= sync2[4];
    end
  end

  assign cs_low = !sync2[5];
  assign cs_rise = sync2[5] && !cs_d;
  assign cs_fall = !sync2[5] && cs_d;
  assign sclk_rise = sync2[4] && !sclk_d;
  assign sio = sync2[3:0];

  // ****************************************
  // Serial shifter and page byte staging
  // ****************************************
  logic [2:0] bitcnt, next_bitcnt;
  logic [2:0] byte_cnt, next_byte_cnt;
  logic quad, next_quad;
  logic stage, next_stage;
  logic got_data, next_got_data;
  logic [7:0] shreg, next_shreg, opcode, next_opcode, col, next_col;
  logic [23:0] addr, next_addr;
  logic pend_valid, next_pend_valid;
  logic [15:0] pend, next_pend;
  logic [7:0] shifted;
  logic [3:0] bit_sum;
  logic fifo_in_ready, fifo_empty;
  sfep_pkg::sfep_state_t state, next_state;
  logic write_unlock_latch, next_wel;

  always_comb begin
    next_bitcnt = bitcnt;
    next_byte_cnt = byte_cnt;
    next_quad = quad;
    next_stage = stage;
    next_got_data = got_data;
    next_shreg = shreg;
    next_opcode = opcode;
    next_col = col;
    next_addr = addr;
    next_pend = pend;
    next_pend_valid = pend_valid && !fifo_in_ready;
    shifted = shreg;
    bit_sum = {1'b0, bitcnt};
    if (cs_fall) begin
      next_bitcnt = 3'h0;
      next_byte_cnt = 3'h0;
      next_quad = 1'b0;
      next_stage = 1'b0;
      next_got_data = 1'b0;
    end else if (cs_low && sclk_rise) begin
      if (quad) begin
        shifted = {shreg[3:0], sio};
        bit_sum = {1'b0, bitcnt} + `SFEP_BIT_STEP_QUAD;
      end else begin
        shifted = {shreg[6:0], sio[0]};
        bit_sum = {1'b0, bitcnt} + `SFEP_BIT_STEP_SINGLE;
      end
      next_shreg = shifted;
      next_bitcnt = bit_sum[2:0];
      if (bit_sum[3]) begin
        if (byte_cnt != `SFEP_BYTES_HEADER) begin
          next_byte_cnt = byte_cnt + 3'h1;
        end
        case (byte_cnt)
          3'h0: begin
            next_opcode = shifted;
            // Four-line framing only when quad lines are enabled
            next_quad = (shifted == `SFEP_OPC_QUAD_PAGE_WRITE) && quad_lines_enable_bit_i;
            // Bytes are staged only for a page write begun in standby with the latch set
            next_stage = ((shifted == `SFEP_OPC_PAGE_WRITE) || next_quad) && write_unlock_latch &&
                         (state == sfep_pkg::SFEP_ST_STANDBY);
          end
          3'h1, 3'h2: begin
            next_addr = {addr[15:0], shifted};
          end
          3'h3: begin
            next_addr = {addr[15:0], shifted};
            next_col = shifted;
          end
          default: begin
            next_got_data = 1'b1;
            if (stage) begin
              // Each byte takes the next column; past the page end the column wraps and overwrites
              next_pend = {col, shifted};
              next_pend_valid = 1'b1;
              next_col = col + 8'h01;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bitcnt <= 3'h0;
      byte_cnt <= 3'h0;
      quad <= 1'b0;
      stage <= 1'b0;
      got_data <= 1'b0;
      shreg <= 8'h00;
      opcode <= 8'h00;
      col <= 8'h00;
      addr <= 24'h00_0000;
      pend_valid <= 1'b0;
      pend <= 16'h0000;
    end else begin
      bitcnt <= next_bitcnt;
      byte_cnt <= next_byte_cnt;
      quad <= next_quad;
      stage <= next_stage;
      got_data <= next_got_data;
      shreg <= next_shreg;
      opcode <= next_opcode;
      col <= next_col;
      addr <= next_addr;
      pend_valid <= next_pend_valid;
      pend <= next_pend;
    end
  end

  // The FIFO absorbs array-side stalls; a byte still pending when the next
  // completes is overwritten, which a stall of over 9 bytes' length would need.
  sfep_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(pend_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pend),
    .out_valid_o(page_byte_valid_o),
    .out_ready_i(page_byte_ready_i),
    .out_data_o({page_byte_col_o, page_byte_o}),
    .empty_o(fifo_empty)
  );

  // ****************************************
  // Command execution and power states
  // ****************************************
  function automatic logic sfep_prot(input logic [23:0] a, input logic [3:0] bp);
    logic [24:0] size;
    size = `SFEP_BLOCK64_SIZE << (bp - 4'h1);
    if (bp == 4'h0) begin
      return 1'b0;
    end
    if (bp >= `SFEP_BP_ALL) begin
      return 1'b1;
    end
    return {1'b0, a} >= (`SFEP_ARRAY_SIZE - size);
  endfunction

  logic [31:0] timer, next_timer;
  logic discard, next_discard, keep_wel, next_keep_wel;
  logic cycle_in_progress_bit, next_wip, sleep, next_sleep;
  logic op_valid, next_op_valid;
  sfep_pkg::sfep_op_t op_kind, next_op_kind;
  logic [23:0] op_addr, next_op_addr;
  logic single, header;

  assign single = (byte_cnt == `SFEP_BYTES_OPCODE) && (bitcnt == 3'h0);
  assign header = (byte_cnt == `SFEP_BYTES_HEADER) && (bitcnt == 3'h0) && !got_data;

  always_comb begin
    next_state = state;
    next_wel = write_unlock_latch;
    next_timer = timer;
    next_discard = discard;
    next_keep_wel = keep_wel;
    next_op_valid = 1'b0;
    next_op_kind = op_kind;
    next_op_addr = op_addr;
    case (state)
      sfep_pkg::SFEP_ST_STANDBY: begin
        if (cs_rise) begin
          if (stage && got_data) begin
            next_state = sfep_pkg::SFEP_ST_FLUSH;
            // Off-boundary release drops the bytes and keeps the latch
            next_keep_wel = (bitcnt != 3'h0);
            next_discard = (bitcnt != 3'h0) || sfep_prot(addr, block_protect_bits_i);
          end else if (single && opcode == `SFEP_OPC_WRITE_UNLOCK) begin
            next_wel = 1'b1;
          end else if (single && opcode == `SFEP_OPC_SLEEP_ENTRY) begin
            next_state = sfep_pkg::SFEP_ST_ENTER_SLEEP;
            next_timer = SLEEP_ENTRY_CYC;
          end else if (single && write_unlock_latch &&
                       (opcode == `SFEP_OPC_ERASE_ALL_A || opcode == `SFEP_OPC_ERASE_ALL_B)) begin
            if (block_protect_bits_i != 4'h0) begin
              next_wel = 1'b0;
            end else begin
              next_state = sfep_pkg::SFEP_ST_BUSY;
              next_timer = ARRAY_ERASE_CYC;
              next_op_valid = 1'b1;
              next_op_kind = sfep_pkg::SFEP_OP_ERASE_ALL;
              next_op_addr = 24'h00_0000;
            end
          end else if (header && write_unlock_latch && opcode == `SFEP_OPC_ERASE64) begin
            if (sfep_prot(addr, block_protect_bits_i)) begin
              next_wel = 1'b0;
            end else begin
              next_state = sfep_pkg::SFEP_ST_BUSY;
              next_timer = BLOCK64_ERASE_CYC;
              next_op_valid = 1'b1;
              next_op_kind = sfep_pkg::SFEP_OP_ERASE64;
              next_op_addr = {addr[23:16], 16'h0000};
            end
          end else if (header && write_unlock_latch && opcode == `SFEP_OPC_ERASE32) begin
            if (sfep_prot(addr, block_protect_bits_i)) begin
              next_wel = 1'b0;
            end else begin
              next_state = sfep_pkg::SFEP_ST_BUSY;
              next_timer = BLOCK32_ERASE_CYC;
              next_op_valid = 1'b1;
              next_op_kind = sfep_pkg::SFEP_OP_ERASE32;
              next_op_addr = {addr[23:15], 15'h0000};
            end
          end
        end
      end
      sfep_pkg::SFEP_ST_FLUSH: begin
        // The op waits until every staged byte has reached the array side
        if (!pend_valid && fifo_empty) begin
          next_op_valid = 1'b1;
          next_op_addr = {addr[23:8], 8'h00};
          if (discard) begin
            next_op_kind = sfep_pkg::SFEP_OP_ABORT;
            next_wel = keep_wel && write_unlock_latch;
            next_state = sfep_pkg::SFEP_ST_STANDBY;
          end else begin
            next_op_kind = sfep_pkg::SFEP_OP_PROGRAM;
            next_state = sfep_pkg::SFEP_ST_BUSY;
            next_timer = PAGE_WRITE_CYC;
          end
        end
      end
      sfep_pkg::SFEP_ST_BUSY: begin
        // Select edges are not looked at here
        if (timer <= 32'h0000_0001) begin
          next_state = sfep_pkg::SFEP_ST_STANDBY;
          next_wel = 1'b0;
        end else begin
          next_timer = timer - 32'h0000_0001;
        end
      end
      sfep_pkg::SFEP_ST_ENTER_SLEEP: begin
        if (timer <= 32'h0000_0001) begin
          next_state = sfep_pkg::SFEP_ST_SLEEP;
        end else begin
          next_timer = timer - 32'h0000_0001;
        end
      end
      sfep_pkg::SFEP_ST_SLEEP: begin
        if (cs_rise && opcode == `SFEP_OPC_SLEEP_RELEASE && bitcnt == 3'h0 &&
            byte_cnt != 3'h0) begin
          next_state = sfep_pkg::SFEP_ST_WAKE;
          next_timer = SLEEP_EXIT_CYC;
        end
      end
      sfep_pkg::SFEP_ST_WAKE: begin
        if (timer <= 32'h0000_0001) begin
          next_state = sfep_pkg::SFEP_ST_STANDBY;
        end else begin
          next_timer = timer - 32'h0000_0001;
        end
      end
      default: begin
        next_state = sfep_pkg::SFEP_ST_STANDBY;
      end
    endcase
    next_wip = (next_state == sfep_pkg::SFEP_ST_BUSY) || (next_state == sfep_pkg::SFEP_ST_FLUSH);
    next_sleep = (next_state == sfep_pkg::SFEP_ST_SLEEP);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= sfep_pkg::SFEP_ST_STANDBY;
      write_unlock_latch <= 1'b0;
      timer <= 32'h0000_0000;
      discard <= 1'b0;
      keep_wel <= 1'b0;
      cycle_in_progress_bit <= 1'b0;
      sleep <= 1'b0;
      op_valid <= 1'b0;
      op_kind <= sfep_pkg::SFEP_OP_ERASE64;
      op_addr <= 24'h00_0000;
    end else begin
      state <= next_state;
      write_unlock_latch <= next_wel;
      timer <= next_timer;
      discard <= next_discard;
      keep_wel <= next_keep_wel;
      cycle_in_progress_bit <= next_wip;
      sleep <= next_sleep;
      op_valid <= next_op_valid;
      op_kind <= next_op_kind;
      op_addr <= next_op_addr;
    end
  end

  assign cycle_in_progress_bit_o = cycle_in_progress_bit;
  assign write_unlock_latch_o = write_unlock_latch;
  assign sleeping_o = sleep;
  assign op_valid_o = op_valid;
  assign op_kind_o = op_kind;
  assign op_addr_o = op_addr;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_e64_align;
    op_valid && op_kind == sfep_pkg::SFEP_OP_ERASE64 |-> op_addr[15:0] == 16'h0000;
  endproperty
  a_e64_align: assert property (p_e64_align) else $error("64K erase address not block aligned");

  property p_e32_align;
    op_valid && op_kind == sfep_pkg::SFEP_OP_ERASE32 |-> op_addr[14:0] == 15'h0000;
  endproperty
  a_e32_align: assert property (p_e32_align) else $error("32K erase address not block aligned");

  property p_all_unprot;
    op_valid && op_kind == sfep_pkg::SFEP_OP_ERASE_ALL |-> $past(block_protect_bits_i) == 4'h0;
  endproperty
  a_all_unprot: assert property (p_all_unprot) else $error("Array erase issued while protected");

  property p_boundary;
    state == sfep_pkg::SFEP_ST_STANDBY && cs_rise && bitcnt != 3'h0 && !stage
      |=> !op_valid && state == sfep_pkg::SFEP_ST_STANDBY;
  endproperty
  a_boundary: assert property (p_boundary) else $error("Off-boundary command executed");

  property p_wel_on_op;
    op_valid && op_kind != sfep_pkg::SFEP_OP_ABORT |-> write_unlock_latch && cycle_in_progress_bit;
  endproperty
  a_wel_on_op: assert property (p_wel_on_op) else $error("Operation issued without latch");

  property p_busy_end;
    $fell(cycle_in_progress_bit) && $past(state == sfep_pkg::SFEP_ST_BUSY) |-> !write_unlock_latch && $past(timer) == 32'h0000_0001;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("Busy ended without clearing latch");

  property p_busy_ignore;
    state == sfep_pkg::SFEP_ST_BUSY && timer > 32'h0000_0002 |=> state == sfep_pkg::SFEP_ST_BUSY ##1 !op_valid;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("Command accepted while busy");

  property p_sleep_delay;
    $rose(sleep) |-> $past(state == sfep_pkg::SFEP_ST_ENTER_SLEEP) && $past(timer) == 32'h0000_0001;
  endproperty
  a_sleep_delay: assert property (p_sleep_delay) else $error("Sleep entered before delay");

  property p_sleep_ignore;
    state == sfep_pkg::SFEP_ST_SLEEP && cs_rise && opcode != `SFEP_OPC_SLEEP_RELEASE
      |=> state == sfep_pkg::SFEP_ST_SLEEP && !op_valid;
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore) else $error("Command heard while asleep");

  property p_release;
    state == sfep_pkg::SFEP_ST_SLEEP && cs_rise && opcode == `SFEP_OPC_SLEEP_RELEASE &&
      bitcnt == 3'h0 && byte_cnt != 3'h0 |=> !sleep ##1 state == sfep_pkg::SFEP_ST_WAKE;
  endproperty
  a_release: assert property (p_release) else $error("Release not taken");

  property p_prot_discard;
    state == sfep_pkg::SFEP_ST_FLUSH && discard && !pend_valid && fifo_empty
      |=> op_valid && op_kind == sfep_pkg::SFEP_OP_ABORT && !cycle_in_progress_bit;
  endproperty
  a_prot_discard: assert property (p_prot_discard) else $error("Discarded page not aborted");

  c_erase64: cover property (op_valid && op_kind == sfep_pkg::SFEP_OP_ERASE64);
  c_program: cover property (op_valid && op_kind == sfep_pkg::SFEP_OP_PROGRAM);
  c_sleep: cover property ($rose(sleep));
  c_wake: cover property ($fell(state == sfep_pkg::SFEP_ST_WAKE));
endmodule // sfep_sequencer

// >>> shared/sfep_consts.svh
// Constants for the serial flash erase / program / power-down sequencer.
// Assumes a 250 MHz core clock; times are kept in microseconds.
`ifndef SFEP_CONSTS_SVH
`define SFEP_CONSTS_SVH

// ****************************************
// Command codes
// ****************************************
`define SFEP_OPC_ERASE64 8'hD8
`define SFEP_OPC_ERASE32 8'h52
`define SFEP_OPC_ERASE_ALL_A 8'h60
`define SFEP_OPC_ERASE_ALL_B 8'hC7
`define SFEP_OPC_PAGE_WRITE 8'h02
`define SFEP_OPC_QUAD_PAGE_WRITE 8'h38
`define SFEP_OPC_SLEEP_RELEASE 8'hAB
// Not given by the command set quoted here; plain defaults
`define SFEP_OPC_WRITE_UNLOCK 8'h06
`define SFEP_OPC_SLEEP_ENTRY 8'hB9

// ****************************************
// Framing and geometry
// ****************************************
`define SFEP_BYTES_OPCODE 3'h1
`define SFEP_BYTES_HEADER 3'h4
`define SFEP_BIT_STEP_SINGLE 4'h1
`define SFEP_BIT_STEP_QUAD 4'h4
`define SFEP_BLOCK64_SIZE 25'h1_0000
`define SFEP_ARRAY_SIZE 25'h100_0000
`define SFEP_BP_ALL 4'h9
`define SFEP_FIFO_DEPTH 8

// ****************************************
// Timing
// ****************************************
`define SFEP_CLK_MHZ 250
`define SFEP_US2CYC(us) ((us) * `SFEP_CLK_MHZ)
`define SFEP_BLOCK64_ERASE_TIME_US 200000
`define SFEP_BLOCK32_ERASE_TIME_US 100000
`define SFEP_ARRAY_ERASE_TIME_US 8000000
`define SFEP_PAGE_WRITE_TIME_US 1000
`define SFEP_SLEEP_ENTRY_DELAY_US 10
`define SFEP_SLEEP_EXIT_DELAY_US 10

`endif

// >>> shared/sfep_pkg.sv
// Types shared by the sequencer and its testbench.
// Assumes sfep_consts.svh supplies all numeric constants.
package sfep_pkg;

  typedef enum logic [2:0] {
    SFEP_ST_STANDBY,
    SFEP_ST_FLUSH,
    SFEP_ST_BUSY,
    SFEP_ST_ENTER_SLEEP,
    SFEP_ST_SLEEP,
    SFEP_ST_WAKE
  } sfep_state_t;

  typedef enum logic [2:0] {
    SFEP_OP_ERASE64,
    SFEP_OP_ERASE32,
    SFEP_OP_ERASE_ALL,
    SFEP_OP_PROGRAM,
    SFEP_OP_ABORT
  } sfep_op_t;

endpackage

// >>> testbench/sfep_host.sv
// Host model: drives select, serial clock and the four data lines.
// Assumes the bench clock; one link bit every 80 ns, clock idle low.
module sfep_host (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // Frames
  // *****
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    data_o = 4'h0;
  end
  function automatic logic [7:0] dat(input int k);
    return k > 255 ? 8'hC3 : 8'(k) ^ 8'h5A;
  endfunction
  task automatic hp();
    repeat (10) @(negedge clk_i);
  endtask
  task automatic bits(input logic [3:0] v);
    data_o = v;
    hp();
    sclk_o = 1'b1;
    hp();
    sclk_o = 1'b0;
  endtask
  // Opcode, three address bytes, then data; xb stray bits break the byte count
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nb, input bit q, input int xb);
    logic [7:0] b;
    cs_n_o = 1'b0;
    hp();
    for (int k = 0; k < nb; k++) begin
      b = k == 0 ? op : k < 4 ? a[8*(3-k) +: 8] : dat(k - 4);
      if (q && k > 0) begin
        bits(b[7:4]);
        bits(b[3:0]);
      end else begin
        for (int j = 7; j >= 0; j--) bits({~{3{b[j]}}, b[j]});
      end
    end
    repeat (xb) bits(4'h1);
    hp();
    cs_n_o = 1'b1;
    // Released lines do not keep their last value
    data_o = ~data_o;
    repeat (4) hp();
  endtask
endmodule // sfep_host

// >>> testbench/testbench.sv
// Bench for the sequencer: a table of erases, then hand-written cases.
// Assumes sfep_host drives the link; the bench is the array side.
`include "sfep_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] a;
    logic [2:0] nb;
    logic [3:0] bp;
    logic fire;
    sfep_pkg::sfep_op_t kind;
    logic [23:0] ea;
  } sfep_row_t;
  localparam sfep_row_t ROWS [6] = '{
    '{8'hD8, 24'h12_3456, 3'h4, 4'h0, 1'b1, sfep_pkg::SFEP_OP_ERASE64, 24'h12_0000},
    '{8'h52, 24'h12_F456, 3'h4, 4'h0, 1'b1, sfep_pkg::SFEP_OP_ERASE32, 24'h12_8000},
    '{8'h60, 24'h00_0000, 3'h1, 4'h0, 1'b1, sfep_pkg::SFEP_OP_ERASE_ALL, 24'h00_0000},
    '{8'hC7, 24'h00_0000, 3'h1, 4'h0, 1'b1, sfep_pkg::SFEP_OP_ERASE_ALL, 24'h00_0000},
    '{8'hD8, 24'hFF_0000, 3'h4, 4'h1, 1'b0, sfep_pkg::SFEP_OP_ERASE64, 24'h00_0000},
    '{8'hC7, 24'h00_0000, 3'h1, 4'h1, 1'b0, sfep_pkg::SFEP_OP_ERASE_ALL, 24'h00_0000}};
  // Distinct busy lengths, so a timer loaded for the wrong operation shows up
  localparam int unsigned CYC_B64 = 1200;
  localparam int unsigned CYC_B32 = 900;
  localparam int unsigned CYC_ALL = 1500;
  localparam int unsigned CYC_PAGE = 700;
  function automatic int busy_len(input sfep_pkg::sfep_op_t k);
    return k == sfep_pkg::SFEP_OP_ERASE64 ? CYC_B64 : k == sfep_pkg::SFEP_OP_ERASE32 ? CYC_B32 : CYC_ALL;
  endfunction
  logic clk, rst_n, rdy, qe, cycle_in_progress_bit, write_unlock_latch, slp, opv, pbv, cs_n, sclk;
  logic [3:0] bp, sio;
  sfep_pkg::sfep_op_t kind, lk;
  logic [23:0] oa, la;
  logic [7:0] col, pb;
  logic [7:0] pg [256];
  int failures, checks_done, nops, nbyt, m0, nw, bl;
  sfep_host h (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .data_o(sio));
  sfep_sequencer #(.BLOCK64_ERASE_CYC(CYC_B64), .BLOCK32_ERASE_CYC(CYC_B32), .ARRAY_ERASE_CYC(CYC_ALL),
    .PAGE_WRITE_CYC(CYC_PAGE)) dut (.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
    .quad_data_lines_i(sio), .quad_lines_enable_bit_i(qe), .block_protect_bits_i(bp),
    .cycle_in_progress_bit_o(cycle_in_progress_bit), .write_unlock_latch_o(write_unlock_latch), .sleeping_o(slp), .op_valid_o(opv),
    .op_kind_o(kind), .op_addr_o(oa), .page_byte_valid_o(pbv), .page_byte_ready_i(rdy),
    .page_byte_col_o(col), .page_byte_o(pb));
  initial begin
    {rst_n, rdy, qe, bp} = 7'h0;
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // *****
  // Array side: stalls every other cycle
  // *****
  always @(negedge clk) rdy <= ~rdy;
  always @(posedge clk) begin
    if (opv === 1'b1) begin
      nops <= nops + 1;
      lk <= kind;
      la <= oa;
    end
    if (pbv === 1'b1 && rdy) begin
      pg[col] <= pb;
      nbyt <= nbyt + 1;
    end
  end
  task automatic chk_b(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_v(input logic [23:0] g, input logic [23:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // 0: latch clear, 1: new op, 2: asleep
  task automatic wait_on(input int sel);
    nw = 0;
    while (!(sel == 0 ? write_unlock_latch === 1'b0 : sel == 1 ? nops != m0 : slp === 1'b1)) begin
      @(negedge clk);
      nw++;
      if (nw > 5000) begin
        failures++;
        $display("ERROR %0t timeout", $time);
        test_done();
      end
    end
  endtask
  task automatic unlock();
    h.frame(`SFEP_OPC_WRITE_UNLOCK, 24'h0, 1, 1'b0, 0);
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int nb, input int xb);
    h.frame(op, a, nb, 1'b0, xb);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    chk_b(write_unlock_latch | cycle_in_progress_bit | slp | opv | pbv, 1'b0);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (ROWS[i]) begin
      bp = ROWS[i].bp;
      unlock();
      chk_b(write_unlock_latch, 1'b1);
      m0 = nops;
      send(ROWS[i].op, ROWS[i].a, ROWS[i].nb, 0);
      chk_b(cycle_in_progress_bit, ROWS[i].fire);
      wait_on(0);
      chk_b(cycle_in_progress_bit, 1'b0);
      // Send returns 40 cycles after select rises; the synchroniser adds 3
      bl = busy_len(ROWS[i].kind);
      if (ROWS[i].fire) chk_b(nw + 40 >= bl && nw + 40 <= bl + 8, 1'b1);
      chk_v(24'(nops - m0), 24'(ROWS[i].fire));
      if (ROWS[i].fire) chk_v({la[23:3], la[2:0] ^ lk}, ROWS[i].ea ^ 24'(ROWS[i].kind));
      $display("row %0d done", i);
    end
    bp = 4'h0;
    unlock();
    m0 = nbyt;
    send(`SFEP_OPC_PAGE_WRITE, 24'h00_34F0, 22, 0);
    wait_on(0);
    chk_v(24'(nbyt - m0), 24'd18);
    chk_v({la, 8'(pg[8'h01] ^ pg[8'hF0])}, {24'h00_3400, 8'(h.dat(17) ^ h.dat(0))});
    qe = 1'b1;
    unlock();
    h.frame(`SFEP_OPC_QUAD_PAGE_WRITE, 24'h00_5600, 262, 1'b1, 0);
    wait_on(0);
    chk_v({pg[0], pg[2], 8'(lk)}, {8'hC3, h.dat(2), 8'(sfep_pkg::SFEP_OP_PROGRAM)});
    bp = 4'h1;
    unlock();
    m0 = nops;
    send(`SFEP_OPC_PAGE_WRITE, 24'hFF_1200, 6, 0);
    wait_on(1);
    chk_v({23'(lk), write_unlock_latch}, {23'(sfep_pkg::SFEP_OP_ABORT), 1'b0});
    bp = 4'h0;
    unlock();
    m0 = nops;
    send(`SFEP_OPC_PAGE_WRITE, 24'h00_0100, 5, 3);
    wait_on(1);
    chk_v({23'(lk), write_unlock_latch}, {23'(sfep_pkg::SFEP_OP_ABORT), 1'b1});
    $display("program done");
    m0 = nops;
    send(`SFEP_OPC_ERASE64, 24'h01_0000, 4, 4);
    repeat (100) @(negedge clk);
    chk_v(24'(nops - m0), 24'h0);
    send(`SFEP_OPC_ERASE64, 24'h01_0000, 4, 0);
    send(`SFEP_OPC_ERASE64, 24'h02_0000, 4, 0);
    wait_on(0);
    chk_v(la, 24'h01_0000);
    m0 = nops;
    send(`SFEP_OPC_ERASE32, 24'h0, 4, 0);
    repeat (100) @(negedge clk);
    chk_v(24'(nops - m0), 24'h0);
    $display("refusal done");
    send(`SFEP_OPC_SLEEP_ENTRY, 24'h0, 1, 2);
    repeat (2600) @(negedge clk);
    chk_b(slp, 1'b0);
    send(`SFEP_OPC_SLEEP_ENTRY, 24'h0, 1, 0);
    wait_on(2);
    chk_b(nw > 2400, 1'b1);
    unlock();
    chk_b(write_unlock_latch, 1'b0);
    send(`SFEP_OPC_SLEEP_RELEASE, 24'h0, 1, 0);
    chk_b(slp, 1'b0);
    repeat (2600) @(negedge clk);
    unlock();
    chk_b(write_unlock_latch, 1'b1);
    send(`SFEP_OPC_SLEEP_ENTRY, 24'h0, 1, 0);
    wait_on(2);
    rst_n = 1'b0;
    @(negedge clk);
    chk_b(slp, 1'b0);
    rst_n = 1'b1;
    $display("sleep done");
    test_done();
  end
endmodule // testbench
